// ### logic/ump_pkg.sv
// Constants shared by the host and modem pin logic of the UART.
// Assumes a single 100 MHz clock and synchronous pin inputs.
package ump_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int LINES = 3;

    // Register offsets on the three address pins
    localparam logic [ADDR_W-1:0] IER_ADDR = 3'h1;
    localparam logic [ADDR_W-1:0] MCR_ADDR = 3'h4;
    localparam logic [ADDR_W-1:0] MSR_ADDR = 3'h6;

    // Field positions
    localparam int IER_MODEM_BIT = 3;
    localparam int MCR_DTR_BIT = 0;
    localparam int MCR_LOOP_BIT = 4;
    localparam int MSR_RING_TRAIL_BIT = 2;
    localparam int MSR_RING_BIT = 6;

    // Modem line indices and where each lands in the status register
    localparam int LINE_CTS = 0;
    localparam int LINE_DSR = 1;
    localparam int LINE_DCD = 2;
    localparam int MSR_DELTA_POS [0:LINES-1] = '{0, 1, 3};
    localparam int MSR_LEVEL_POS [0:LINES-1] = '{4, 5, 7};

    // Reset values
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 3'h0;
    localparam logic [LINES-1:0] LINES_IDLE_N = 3'h7;
    localparam logic [LINES-1:0] FLAGS_RESET = 3'h0;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_READ,
        BUS_WRITE
    } ump_bus_state_t;
endpackage

// ### logic/ump_link_if.sv
// Carrier between the pin logic top, its select latch and its modem status block.
// Assumes all three modules share one clock.
`timescale 1ns/1ps
interface ump_link_if;
    logic selected;
    logic [ump_pkg::ADDR_W-1:0] reg_addr;
    logic msr_clear;
    logic [ump_pkg::LINES-1:0] line_changed;
    logic [ump_pkg::DATA_W-1:0] msr_value;

    modport latch (output selected, output reg_addr);
    modport status (input msr_clear, output line_changed, output msr_value);
    modport core (input selected, input reg_addr, output msr_clear,
        input line_changed, input msr_value);
endinterface

// ### logic/ump_select_latch.sv
// Chip select decode and address strobe hold for the host port.
// Assumes select, address and strobe pins are synchronous to clock_in.
`timescale 1ns/1ps
module ump_select_latch (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic address_latch_strobe_n_in,
    input wire logic select_in_high_a_in,
    input wire logic select_in_high_b_in,
    input wire logic select_in_low_n_in,
    input wire logic [ump_pkg::ADDR_W-1:0] addr_in,
    ump_link_if.latch link
);
    logic live_sel;
    logic sel_held_reg;
    logic [ump_pkg::ADDR_W-1:0] addr_held_reg;

    // All three selects must agree; any inactive one deselects
    assign live_sel = select_in_high_a_in & select_in_high_b_in & ~select_in_low_n_in;

    // Held copy tracks the pins while the strobe is low, so it freezes at the rising edge
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sel_held_reg <= 1'b0;
            addr_held_reg <= ump_pkg::ADDR_RESET;
        end else if (!address_latch_strobe_n_in) begin
            sel_held_reg <= live_sel;
            addr_held_reg <= addr_in;
        end
    end

    assign link.selected = address_latch_strobe_n_in ? sel_held_reg : live_sel;
    assign link.reg_addr = address_latch_strobe_n_in ? addr_held_reg : addr_in;
endmodule

// ### logic/ump_modem_status.sv
// Modem line level and change flags, packed as the modem status byte.
// Assumes modem lines are synchronous, active low, and idle high.
`timescale 1ns/1ps
module ump_modem_status (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [ump_pkg::LINES-1:0] line_n_in,
    ump_link_if.status link
);
    logic armed_reg;
    logic [ump_pkg::LINES-1:0] prev_reg;
    logic [ump_pkg::LINES-1:0] delta_reg;
    logic [ump_pkg::LINES-1:0] delta_next;

    // First cycle after reset only samples, so a line already low is not a change
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            armed_reg <= 1'b0;
            prev_reg <= ump_pkg::LINES_IDLE_N;
            delta_reg <= ump_pkg::FLAGS_RESET;
        end else begin
            armed_reg <= 1'b1;
            prev_reg <= line_n_in;
            delta_reg <= delta_next;
        end
    end

    genvar i;
    generate
        for (i = 0; i < ump_pkg::LINES; i++) begin : g_line
            // A new change wins over the clear of the same cycle
            assign delta_next[i] = (armed_reg & (line_n_in[i] != prev_reg[i]))
                | (delta_reg[i] & ~link.msr_clear);
            assign link.msr_value[ump_pkg::MSR_DELTA_POS[i]] = delta_reg[i];
            assign link.msr_value[ump_pkg::MSR_LEVEL_POS[i]] = ~line_n_in[i];
        end
    endgenerate

    // Ring indicator is not handled here
    assign link.msr_value[ump_pkg::MSR_RING_TRAIL_BIT] = 1'b0;
    assign link.msr_value[ump_pkg::MSR_RING_BIT] = 1'b0;
    assign link.line_changed = delta_reg;
endmodule

// ### logic/ump_host_pins.sv
// Host bus and modem handshake pin logic of a single-channel UART.
// Assumes the surrounding UART supplies the serial core's status and read data,
// and that all pins are synchronous to clock_in.
//
// Functional notes
// - Selected when both highs high, low low
// - Any inactive select ignores host cycles
// - Status bit 4 shows clear-to-send level
// - Status bit 0 flags clear-to-send change
// - Clear-to-send change interrupts when enabled, unless auto mode
// - Auto mode: clear-to-send gates transmitter
// - Eight-bit data bus driven only on reads
// - Status bit 7 shows carrier level
// - Status bit 3 flags carrier change
// - Carrier or set-ready change interrupts when enabled
// - Status bit 5 shows data-set-ready level
// - Status bit 1 flags data-set-ready change
// - Transceiver disable low except during reads
// - Terminal-ready active when control bit set
// - Terminal-ready inactive: reset, loopback, bit clear
// - Interrupt high while any condition pending
// - Interrupt sources: errors, data, timeout, empty, modem
// - Interrupt drops once serviced or reset
// - Strobe low passes selects; rising edge holds
`timescale 1ns/1ps
module ump_host_pins (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic select_in_high_a_in,
    input wire logic select_in_high_b_in,
    input wire logic select_in_low_n_in,
    input wire logic address_latch_strobe_n_in,
    input wire logic [ump_pkg::ADDR_W-1:0] addr_in,
    input wire logic read_n_in,
    input wire logic write_n_in,
    input wire logic [ump_pkg::DATA_W-1:0] data_in,
    output logic [ump_pkg::DATA_W-1:0] data_out,
    output logic data_oe_n_out,
    output logic transceiver_off_n_out,
    input wire logic cts_n_in,
    input wire logic dsr_n_in,
    input wire logic dcd_n_in,
    output logic dtr_n_out,
    input wire logic auto_cts_en_in,
    output logic tx_allowed_out,
    input wire logic rx_error_in,
    input wire logic rx_data_avail_in,
    input wire logic rx_timeout_in,
    input wire logic fifo_mode_in,
    input wire logic thr_empty_in,
    input wire logic [ump_pkg::DATA_W-1:0] core_read_data_in,
    output logic [ump_pkg::ADDR_W-1:0] core_addr_out,
    output logic core_read_out,
    output logic core_write_out,
    output logic [ump_pkg::DATA_W-1:0] core_write_data_out,
    output logic loopback_out,
    output logic int_out
);
    ump_link_if link ();

    ump_pkg::ump_bus_state_t bus_state_reg;
    ump_pkg::ump_bus_state_t bus_state_next;
    logic read_act;
    logic write_act;
    logic read_start;
    logic write_start;
    logic msr_hit;
    logic mcr_hit;
    logic ier_hit;
    logic [ump_pkg::DATA_W-1:0] read_value;
    logic [ump_pkg::DATA_W-1:0] data_reg;
    logic [ump_pkg::ADDR_W-1:0] core_addr_reg;
    logic core_read_reg;
    logic core_write_reg;
    logic [ump_pkg::DATA_W-1:0] core_wdata_reg;
    logic dtr_bit_reg;
    logic loop_bit_reg;
    logic modem_int_en_reg;
    logic cts_irq;
    logic modem_irq;
    logic int_next;
    logic int_reg;

    ump_select_latch u_select (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .address_latch_strobe_n_in(address_latch_strobe_n_in),
        .select_in_high_a_in(select_in_high_a_in),
        .select_in_high_b_in(select_in_high_b_in),
        .select_in_low_n_in(select_in_low_n_in),
        .addr_in(addr_in),
        .link(link.latch)
    );

    ump_modem_status u_status (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .line_n_in({dcd_n_in, dsr_n_in, cts_n_in}),
        .link(link.status)
    );

    // Host cycles only count while selected
    assign read_act = link.selected & ~read_n_in;
    assign write_act = link.selected & ~write_n_in;
    assign read_start = (bus_state_reg == ump_pkg::BUS_IDLE) & read_act;
    assign write_start = (bus_state_reg == ump_pkg::BUS_IDLE) & write_act & ~read_act;

    assign msr_hit = link.reg_addr == ump_pkg::MSR_ADDR;
    assign mcr_hit = link.reg_addr == ump_pkg::MCR_ADDR;
    assign ier_hit = link.reg_addr == ump_pkg::IER_ADDR;

    // One action per strobe: a long read still clears the flags only once
    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            ump_pkg::BUS_IDLE: begin
                if (read_act) begin
                    bus_state_next = ump_pkg::BUS_READ;
                end else if (write_act) begin
                    bus_state_next = ump_pkg::BUS_WRITE;
                end
            end
            ump_pkg::BUS_READ: begin
                if (!read_act) begin
                    bus_state_next = ump_pkg::BUS_IDLE;
                end
            end
            ump_pkg::BUS_WRITE: begin
                if (!write_act) begin
                    bus_state_next = ump_pkg::BUS_IDLE;
                end
            end
            default: begin
                bus_state_next = ump_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            bus_state_reg <= ump_pkg::BUS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // Data captured at the same edge that clears the flags, so the read sees them set
    assign link.msr_clear = read_start & msr_hit;
    assign read_value = msr_hit ? link.msr_value : core_read_data_in;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            data_reg <= ump_pkg::DATA_RESET;
        end else if (read_start) begin
            data_reg <= read_value;
        end
    end

    assign data_out = data_reg;
    assign data_oe_n_out = ~read_act;
    assign transceiver_off_n_out = read_act;

    // Local control bits mirrored from host writes
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            dtr_bit_reg <= 1'b0;
            loop_bit_reg <= 1'b0;
            modem_int_en_reg <= 1'b0;
        end else if (write_start && mcr_hit) begin
            dtr_bit_reg <= data_in[ump_pkg::MCR_DTR_BIT];
            loop_bit_reg <= data_in[ump_pkg::MCR_LOOP_BIT];
        end else if (write_start && ier_hit) begin
            modem_int_en_reg <= data_in[ump_pkg::IER_MODEM_BIT];
        end
    end

    assign dtr_n_out = ~(dtr_bit_reg & ~loop_bit_reg);
    assign loopback_out = loop_bit_reg;
    assign tx_allowed_out = ~auto_cts_en_in | ~cts_n_in;

    // Hand-off of every selected cycle to the serial core
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            core_addr_reg <= ump_pkg::ADDR_RESET;
            core_read_reg <= 1'b0;
            core_write_reg <= 1'b0;
            core_wdata_reg <= ump_pkg::DATA_RESET;
        end else begin
            core_read_reg <= read_start;
            core_write_reg <= write_start;
            if (read_start || write_start) begin
                core_addr_reg <= link.reg_addr;
                core_wdata_reg <= data_in;
            end
        end
    end

    assign core_addr_out = core_addr_reg;
    assign core_read_out = core_read_reg;
    assign core_write_out = core_write_reg;
    assign core_write_data_out = core_wdata_reg;

    // The clear-to-send flag still records changes in auto mode, it just stays quiet
    assign cts_irq = link.line_changed[ump_pkg::LINE_CTS] & ~auto_cts_en_in;
    assign modem_irq = modem_int_en_reg & (cts_irq
        | link.line_changed[ump_pkg::LINE_DSR]
        | link.line_changed[ump_pkg::LINE_DCD]);
    assign int_next = rx_error_in | rx_data_avail_in | (rx_timeout_in & fifo_mode_in)
        | thr_empty_in | modem_irq;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            int_reg <= 1'b0;
        end else begin
            int_reg <= int_next;
        end
    end

    assign int_out = int_reg;
endmodule

// ### test/ump_host_pins_assertions.sv
// Checker for the host and modem pin logic, watching the top module's ports.
// Assumes one clock domain and that the strobe is low whenever the live decode is used.
`timescale 1ns/1ps
module ump_host_pins_assertions (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic select_in_high_a_in,
    input wire logic select_in_high_b_in,
    input wire logic select_in_low_n_in,
    input wire logic address_latch_strobe_n_in,
    input wire logic [ump_pkg::ADDR_W-1:0] addr_in,
    input wire logic read_n_in,
    input wire logic write_n_in,
    input wire logic data_oe_n_out,
    input wire logic transceiver_off_n_out,
    input wire logic cts_n_in,
    input wire logic dtr_n_out,
    input wire logic auto_cts_en_in,
    input wire logic tx_allowed_out,
    input wire logic rx_error_in,
    input wire logic rx_data_avail_in,
    input wire logic rx_timeout_in,
    input wire logic fifo_mode_in,
    input wire logic thr_empty_in,
    input wire logic [ump_pkg::ADDR_W-1:0] core_addr_out,
    input wire logic core_read_out,
    input wire logic core_write_out,
    input wire logic loopback_out,
    input wire logic int_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // Only meaningful while the strobe passes the pins straight through
    wire pins_on = select_in_high_a_in & select_in_high_b_in & ~select_in_low_n_in;
    wire sel_live = ~address_latch_strobe_n_in & pins_on;
    wire any_src = rx_error_in | rx_data_avail_in | (rx_timeout_in & fifo_mode_in) | thr_empty_in;
    sequence rd_start;
        $fell(read_n_in) && sel_live;
    endsequence
    sequence wr_start;
        $fell(write_n_in) && read_n_in && sel_live;
    endsequence
    chk_deselect_quiet: assert property (!address_latch_strobe_n_in && !pins_on
        |-> data_oe_n_out)
        else $error("bus driven while deselected");
    chk_read_drives: assert property (sel_live && !read_n_in |-> !data_oe_n_out)
        else $error("selected read not driven");
    chk_xcvr_read: assert property (!address_latch_strobe_n_in
        |-> transceiver_off_n_out == (pins_on && !read_n_in))
        else $error("transceiver disable wrong");
    chk_tx_gate: assert property (tx_allowed_out == (!auto_cts_en_in || !cts_n_in))
        else $error("transmit gate wrong");
    chk_int_source: assert property (any_src |=> int_out)
        else $error("interrupt missing");
    chk_int_reset: assert property ($fell(rst_in) |-> !int_out)
        else $error("interrupt after reset");
    chk_dtr_loop: assert property (loopback_out |-> dtr_n_out)
        else $error("terminal ready in loop");
    chk_read_pulse: assert property (rd_start |=> core_read_out ##1 !core_read_out)
        else $error("read pulse wrong");
    chk_write_pulse: assert property (wr_start |=> core_write_out ##1 !core_write_out)
        else $error("write pulse wrong");
    chk_addr_pass: assert property (core_read_out && !$past(address_latch_strobe_n_in)
        |-> core_addr_out == $past(addr_in))
        else $error("address not passed");
endmodule
bind ump_host_pins ump_host_pins_assertions u_chk (.clock_in, .rst_in, .select_in_high_a_in,
    .select_in_high_b_in, .select_in_low_n_in, .address_latch_strobe_n_in, .addr_in,
    .read_n_in, .write_n_in, .data_oe_n_out, .transceiver_off_n_out, .cts_n_in, .dtr_n_out,
    .auto_cts_en_in, .tx_allowed_out, .rx_error_in, .rx_data_avail_in, .rx_timeout_in,
    .fifo_mode_in, .thr_empty_in, .core_addr_out, .core_read_out, .core_write_out,
    .loopback_out, .int_out);

// ### test/ump_modem_model.sv
// Model of the modem side: three active-low status lines, idle high.
// Assumes the bench asks for line changes; each lands just after a rising edge.
`timescale 1ns/1ps
module ump_modem_model (
    input wire logic clock_in,
    output logic cts_n_out,
    output logic dsr_n_out,
    output logic dcd_n_out
);
    logic [2:0] lines_reg = 3'h7;
    assign cts_n_out = lines_reg[ump_pkg::LINE_CTS];
    assign dsr_n_out = lines_reg[ump_pkg::LINE_DSR];
    assign dcd_n_out = lines_reg[ump_pkg::LINE_DCD];
    task automatic drive(input logic [2:0] v);
        @(posedge clock_in);
        lines_reg <= v;
    endtask
endmodule

// ### test/ump_host_pins_tb.sv
// Bench for the host and modem pin logic: host cycles by task, modem lines by model.
// Assumes the strobe stays low except in the hold scenario.
`timescale 1ns/1ps
module ump_host_pins_tb;
    logic clock_in = 1'h0;
    logic rst_in = 1'h1;
    logic sa = 1'h1, sb = 1'h1, sln = 1'h0, stb_n = 1'h0, rd_n = 1'h1, wr_n = 1'h1;
    logic auto_cts = 1'h0, fifo = 1'h0;
    logic [3:0] src = 4'h0;
    logic [2:0] addr = 3'h0;
    logic [7:0] din = 8'h00, core_rd = 8'h5A;
    logic [7:0] dout, cwd;
    logic [2:0] caddr;
    logic oe_n, xoff_n, cts_n, dsr_n, dcd_n, dtr_n, txa, crd, cwr, loop, intr;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #5 clock_in = ~clock_in;
    ump_modem_model m (.clock_in(clock_in), .cts_n_out(cts_n), .dsr_n_out(dsr_n),
        .dcd_n_out(dcd_n));
    ump_host_pins dut (.clock_in(clock_in), .rst_in(rst_in), .select_in_high_a_in(sa),
        .select_in_high_b_in(sb), .select_in_low_n_in(sln), .address_latch_strobe_n_in(stb_n),
        .addr_in(addr), .read_n_in(rd_n), .write_n_in(wr_n), .data_in(din), .data_out(dout),
        .data_oe_n_out(oe_n), .transceiver_off_n_out(xoff_n), .cts_n_in(cts_n),
        .dsr_n_in(dsr_n), .dcd_n_in(dcd_n), .dtr_n_out(dtr_n), .auto_cts_en_in(auto_cts),
        .tx_allowed_out(txa), .rx_error_in(src[0]), .rx_data_avail_in(src[1]),
        .rx_timeout_in(src[2]), .fifo_mode_in(fifo), .thr_empty_in(src[3]),
        .core_read_data_in(core_rd), .core_addr_out(caddr), .core_read_out(crd),
        .core_write_out(cwr), .core_write_data_out(cwd), .loopback_out(loop), .int_out(intr));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_in);
        addr <= a;
        din <= d;
        wr_n <= 1'h0;
        @(posedge clock_in);
        wr_n <= 1'h1;
        tick(1);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clock_in);
        addr <= a;
        rd_n <= 1'h0;
        tick(1);
        chk(dout, exp);
        chk(oe_n, 1'h0);
        chk(xoff_n, 1'h1);
        @(posedge clock_in);
        rd_n <= 1'h1;
        tick(1);
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clock_in);
        rst_in <= 1'h0;
        tick(1);
        chk(dtr_n, 1'h1);
        chk(intr, 1'h0);
        chk(oe_n, 1'h1);
        for (int k = 0; k < 4; k++) begin
            fifo <= 1'h1;
            src <= 4'(1 << k);
            tick(2);
            chk(intr, 1'h1);
            src <= 4'h0;
            tick(2);
            chk(intr, 1'h0);
        end
        fifo <= 1'h0;
        src <= 4'h4;
        tick(3);
        chk(intr, 1'h0);
        src <= 4'h0;
        wr(ump_pkg::IER_ADDR, 8'h08);
        rd(ump_pkg::MSR_ADDR, 8'h00);
        for (int i = 0; i < 3; i++) begin
            m.drive(3'h7 ^ 3'(1 << i));
            tick(3);
            chk(intr, 1'h1);
            rd(ump_pkg::MSR_ADDR, 8'(1 << ump_pkg::MSR_DELTA_POS[i])
                | 8'(1 << ump_pkg::MSR_LEVEL_POS[i]));
            chk(intr, 1'h0);
            m.drive(3'h7);
            tick(3);
            rd(ump_pkg::MSR_ADDR, 8'(1 << ump_pkg::MSR_DELTA_POS[i]));
            chk(intr, 1'h0);
        end
        auto_cts <= 1'h1;
        m.drive(3'h6);
        tick(3);
        chk(txa, 1'h1);
        chk(intr, 1'h0);
        m.drive(3'h7);
        tick(3);
        chk(txa, 1'h0);
        rd(ump_pkg::MSR_ADDR, 8'h01);
        auto_cts <= 1'h0;
        @(posedge clock_in);
        sln <= 1'h1;
        rd_n <= 1'h0;
        tick(1);
        chk(oe_n, 1'h1);
        chk(xoff_n, 1'h0);
        @(posedge clock_in);
        rd_n <= 1'h1;
        wr(ump_pkg::MCR_ADDR, 8'h01);
        chk(dtr_n, 1'h1);
        sln <= 1'h0;
        wr(ump_pkg::MCR_ADDR, 8'h01);
        chk(dtr_n, 1'h0);
        // Mid-run reset with terminal ready and an interrupt both active
        src <= 4'h8;
        tick(2);
        chk(intr, 1'h1);
        rst_in <= 1'h1;
        src <= 4'h0;
        tick(1);
        chk(dtr_n, 1'h1);
        chk(intr, 1'h0);
        rst_in <= 1'h0;
        tick(2);
        wr(ump_pkg::MCR_ADDR, 8'h11);
        chk(cwd, 8'h11);
        chk(dtr_n, 1'h1);
        chk(loop, 1'h1);
        wr(ump_pkg::MCR_ADDR, 8'h00);
        chk(dtr_n, 1'h1);
        // Hold a selected decode of address 2, then move the pins away
        addr <= 3'h2;
        tick(2);
        stb_n <= 1'h1;
        sln <= 1'h1;
        rd(3'h5, 8'h5A);
        chk(8'(caddr), 8'h02);
        stb_n <= 1'h0;
        sln <= 1'h0;
        tick(2);
        wrap_up();
    end
endmodule
